/* File: logic/fieldbus_trouble_logger.sv */
// What this block does
// - Log holds up to eight records: code, detail length, detail data.
// - Each accepted trouble is stored in log words 2040 to 2079.
// - Mode select input chooses ring (low) or fixed (high) log behaviour.
// - Ring mode shifts records down; newest always sits in the head slot.
// - Fixed mode, when full, keeps slots 2-8 and overwrites slot 1 only.
// - Log clear request erases every record in both modes.
// - Flag reset request drops the detected flag, log contents kept.
// - Extended area keeps only the latest extended record of code 0200H.
// - Word 2096 holds extended data byte length; data starts at word 2098.
// - Overflow word: only bit 7, set for 27 or more extended bytes.
// - Device diagnostics stored as one-byte header plus slave trouble bytes.
// - Identifier diagnostics stored after a header, one bit per module.
// - Channel diagnostics follow, headerless, three bytes per entry.
// - Set mask bit ignores a category, clear bit accepts; reset 02B9H.
// - Mask bits 0-7: param, diag read, zero, watchdog, freeze, sync, reserved, excluded.
// - Mask bits 8-15: exchange, not ready, length, ext diag, func, response, param, master.
// - Masked troubles raise no flag, indicator, records or station status.
// - Mask writes are ignored while exchange start request is high.
// - Layout reload request clears log, extended area and indicator, like log clear.
// - Trouble reporting suppressed for programmable seconds after exchange start.
`include "trouble_logger_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module fieldbus_trouble_logger #(
    parameter int unsigned LOG_DEPTH = 8,
    parameter int unsigned CYCLES_PER_SECOND = (`CLK_HZ * `SECOND_S)
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [13:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Host handshake
    input wire logic log_mode_select_i,
    input wire logic log_clear_request_i,
    input wire logic detect_flag_reset_i,
    input wire logic exchange_start_request_i,
    input wire logic layout_reload_i,
    output logic trouble_detected_flag_o,
    output logic response_error_indicator_o,
    // Trouble reports from slave stations
    input wire logic trouble_valid_i,
    input wire logic [15:0] trouble_code_i,
    input wire logic [15:0] trouble_cat_i,
    input wire logic [6:0] trouble_station_i,
    input wire logic [7:0] trouble_len_i,
    input wire logic [47:0] trouble_detail_i,
    // Extended diagnostic byte stream
    input wire logic ext_valid_i,
    input wire logic [7:0] ext_byte_i,
    input wire logic ext_last_i,
    // Station status
    output logic station_fault_o,
    output logic [6:0] station_fault_id_o
);
    import trouble_logger_pkg::*;

    // ****************************************
    // Functions
    // ****************************************
    function automatic logic [15:0] rec_word(input trouble_rec_s rec, input logic [2:0] sel);
        case (sel)
            3'h0: rec_word = rec.code;
            3'h1: rec_word = {8'h00, rec.len};
            3'h2: rec_word = rec.detail[15:0];
            3'h3: rec_word = rec.detail[31:16];
            3'h4: rec_word = rec.detail[47:32];
            default: rec_word = 16'h0000;
        endcase
    endfunction : rec_word

    function automatic logic in_range(input logic [11:0] idx, input logic [11:0] lo, input logic [11:0] hi);
        in_range = (idx >= lo) && (idx <= hi);
    endfunction : in_range

    // ****************************************
    // Declarations
    // ****************************************
    localparam logic [25:0] SEC_LAST = 26'(CYCLES_PER_SECOND - 1);
    localparam logic [3:0] DEPTH = 4'(LOG_DEPTH);

    trouble_rec_s log_q [LOG_DEPTH];
    logic [3:0] count_q;
    logic [15:0] mask_q;
    logic [15:0] supp_time_q;
    logic [15:0] supp_left_q;
    logic [25:0] sec_cnt_q;
    logic xs_q;
    logic flag_q;
    logic led_q;
    logic fault_q;
    logic [6:0] fault_id_q;
    logic [7:0] ext_bytes_q [`EXT_STORE_BYTES];
    logic [7:0] ext_len_q;
    logic [7:0] ext_total_q;
    logic ext_ovf_q;
    ext_state_e ext_state_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;

    logic [11:0] idx;
    logic apb_wr;
    logic apb_rd_take;
    logic suppress;
    logic accept;
    logic wipe;
    logic [11:0] log_off;
    logic [3:0] rec_sel;
    logic [2:0] word_sel;
    logic [11:0] ext_off;
    logic [15:0] rd_word;
    logic rd_hit;

    assign idx = paddr_i[13:2];
    assign apb_wr = psel_i && penable_i && pwrite_i && pready_q;
    assign apb_rd_take = psel_i && penable_i && !pready_q;
    assign wipe = log_clear_request_i || layout_reload_i;
    assign suppress = exchange_start_request_i && (supp_left_q != 16'h0000);
    assign accept = trouble_valid_i && !suppress
        && ((trouble_cat_i == 16'h0000) || ((trouble_cat_i & ~mask_q) != 16'h0000));

    // ****************************************
    // Mask and suppression time registers
    // ****************************************
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            mask_q <= `MASK_RESET;
            supp_time_q <= `SUPPRESS_RESET;
        end
        else if (apb_wr && !exchange_start_request_i)
        begin
            if (idx == `IDX_SLAVE_TROUBLE_MASK)
            begin
                mask_q <= pwdata_i[15:0] & ~`MASK_FIXED_ZERO;
            end
            if (idx == `IDX_SUPPRESS_TIME)
            begin
                supp_time_q <= pwdata_i[15:0];
            end
        end
    end

    // ****************************************
    // Suppression countdown
    // ****************************************
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            xs_q <= 1'b0;
            supp_left_q <= 16'h0000;
            sec_cnt_q <= 26'h0000000;
        end
        else
        begin
            xs_q <= exchange_start_request_i;
            if (exchange_start_request_i && !xs_q)
            begin
                supp_left_q <= supp_time_q;
                sec_cnt_q <= 26'h0000000;
            end
            else if (supp_left_q != 16'h0000)
            begin
                if (sec_cnt_q == SEC_LAST)
                begin
                    sec_cnt_q <= 26'h0000000;
                    supp_left_q <= supp_left_q - 16'h0001;
                end
                else
                begin
                    sec_cnt_q <= sec_cnt_q + 26'h0000001;
                end
            end
        end
    end

    // ****************************************
    // Trouble log
    // ****************************************
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            count_q <= 4'h0;
            for (int i = 0; i < LOG_DEPTH; i++)
            begin
                log_q[i] <= '0;
            end
        end
        else if (wipe)
        begin
            count_q <= 4'h0;
            for (int i = 0; i < LOG_DEPTH; i++)
            begin
                log_q[i] <= '0;
            end
        end
        else if (accept)
        begin
            if (!(log_mode_select_i && (count_q == DEPTH)))
            begin
                for (int i = LOG_DEPTH - 1; i > 0; i--)
                begin
                    log_q[i] <= log_q[i - 1];
                end
            end
            log_q[0] <= '{code: trouble_code_i, len: trouble_len_i, detail: trouble_detail_i};
            if (count_q != DEPTH)
            begin
                count_q <= count_q + 4'h1;
            end
        end
    end

    // ****************************************
    // Detected flag, indicator, station status
    // ****************************************
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            flag_q <= 1'b0;
            led_q <= 1'b0;
            fault_q <= 1'b0;
            fault_id_q <= 7'h00;
        end
        else
        begin
            fault_q <= accept;
            if (accept)
            begin
                fault_id_q <= trouble_station_i;
            end
            if (accept)
            begin
                flag_q <= 1'b1;
            end
            else if (detect_flag_reset_i)
            begin
                flag_q <= 1'b0;
            end
            if (accept)
            begin
                led_q <= 1'b1;
            end
            else if (wipe)
            begin
                led_q <= 1'b0;
            end
        end
    end

    // ****************************************
    // Extended trouble capture
    // ****************************************
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            ext_state_q <= EXT_IDLE;
            ext_len_q <= 8'h00;
            ext_total_q <= 8'h00;
            ext_ovf_q <= 1'b0;
            for (int i = 0; i < `EXT_STORE_BYTES; i++)
            begin
                ext_bytes_q[i] <= 8'h00;
            end
        end
        else if (wipe)
        begin
            ext_state_q <= EXT_IDLE;
            ext_len_q <= 8'h00;
            ext_total_q <= 8'h00;
            ext_ovf_q <= 1'b0;
            for (int i = 0; i < `EXT_STORE_BYTES; i++)
            begin
                ext_bytes_q[i] <= 8'h00;
            end
        end
        else
        begin
            case (ext_state_q)
                EXT_IDLE:
                begin
                    if (accept && (trouble_code_i == `EXT_TROUBLE_CODE))
                    begin
                        ext_state_q <= EXT_ARMED;
                    end
                end
                EXT_ARMED, EXT_CAPTURE:
                begin
                    if (ext_valid_i)
                    begin
                        // Headers and blocks are kept byte for byte as sent
                        if (ext_state_q == EXT_ARMED)
                        begin
                            ext_bytes_q[0] <= ext_byte_i;
                            ext_len_q <= 8'h01;
                            ext_total_q <= 8'h01;
                            ext_ovf_q <= 1'b0;
                        end
                        else
                        begin
                            if (ext_total_q < 8'(`EXT_STORE_BYTES))
                            begin
                                ext_bytes_q[5'(ext_total_q)] <= ext_byte_i;
                                ext_len_q <= ext_total_q + 8'h01;
                            end
                            if (ext_total_q != 8'hFF)
                            begin
                                ext_total_q <= ext_total_q + 8'h01;
                            end
                            if (ext_total_q >= 8'(`EXT_OVERFLOW_BYTES - 1))
                            begin
                                ext_ovf_q <= 1'b1;
                            end
                        end
                        ext_state_q <= ext_last_i ? EXT_IDLE : EXT_CAPTURE;
                    end
                end
                default:
                begin
                    ext_state_q <= EXT_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // Read decode
    // ****************************************
    always_comb
    begin
        log_off = idx - `IDX_LOG_FIRST;
        ext_off = idx - `IDX_EXT_DATA_FIRST;
        rec_sel = 4'(log_off / `LOG_WORDS_PER_REC);
        word_sel = 3'(log_off % `LOG_WORDS_PER_REC);
        rd_word = 16'h0000;
        rd_hit = 1'b1;
        if (in_range(idx, `IDX_LOG_FIRST, `IDX_LOG_LAST))
        begin
            rd_word = rec_word(log_q[rec_sel[2:0]], word_sel);
        end
        else if (idx == `IDX_SLAVE_TROUBLE_MASK)
        begin
            rd_word = mask_q;
        end
        else if (idx == `IDX_SUPPRESS_TIME)
        begin
            rd_word = supp_time_q;
        end
        else if (idx == `IDX_EXT_LENGTH)
        begin
            rd_word = {8'h00, ext_len_q};
        end
        else if (idx == `IDX_EXT_OVERFLOW)
        begin
            rd_word = {8'h00, ext_ovf_q, 7'h00};
        end
        else if (in_range(idx, `IDX_EXT_DATA_FIRST, `IDX_EXT_DATA_LAST))
        begin
            rd_word = {ext_bytes_q[5'({ext_off[3:0], 1'b1})], ext_bytes_q[5'({ext_off[3:0], 1'b0})]};
        end
        else
        begin
            rd_hit = 1'b0;
        end
    end

    // ****************************************
    // APB response
    // ****************************************
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            prdata_q <= 32'h00000000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else if (apb_rd_take)
        begin
            pready_q <= 1'b1;
            pslverr_q <= !rd_hit;
            prdata_q <= pwrite_i ? 32'h00000000 : {16'h0000, rd_word};
        end
        else
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end
    end

    assign prdata_o = prdata_q;
    assign pready_o = pready_q;
    assign pslverr_o = pslverr_q;
    assign trouble_detected_flag_o = flag_q;
    assign response_error_indicator_o = led_q;
    assign station_fault_o = fault_q;
    assign station_fault_id_o = fault_id_q;

endmodule : fieldbus_trouble_logger

`default_nettype wire

/* File: logic/trouble_logger_defines.svh */
`ifndef TROUBLE_LOGGER_DEFINES_SVH
`define TROUBLE_LOGGER_DEFINES_SVH

// ****************************************
// Word indices (byte address = 4 * index)
// ****************************************
`define IDX_LOG_FIRST 12'h7F8
`define IDX_LOG_LAST 12'h81F
`define IDX_SLAVE_TROUBLE_MASK 12'h820
`define IDX_SUPPRESS_TIME 12'h824
`define IDX_EXT_LENGTH 12'h830
`define IDX_EXT_OVERFLOW 12'h831
`define IDX_EXT_DATA_FIRST 12'h832
`define IDX_EXT_DATA_LAST 12'h83E

// ****************************************
// Reset values and fields
// ****************************************
`define MASK_RESET 16'h02B9
`define MASK_FIXED_ZERO 16'h0044
`define SUPPRESS_RESET 16'h0014
`define EXT_TROUBLE_CODE 16'h0200
`define EXT_OVERFLOW_BIT 7
`define EXT_OVERFLOW_BYTES 27
`define EXT_STORE_BYTES 26
`define LOG_WORDS_PER_REC 5

// ****************************************
// Timing
// ****************************************
`define CLK_HZ 50000000
`define SECOND_S 1

`endif

/* File: logic/trouble_logger_pkg.sv */
package trouble_logger_pkg;

    typedef struct packed {
        logic [15:0] code;
        logic [7:0] len;
        logic [47:0] detail;
    } trouble_rec_s;

    typedef enum logic [1:0] {
        EXT_IDLE = 2'b00,
        EXT_ARMED = 2'b01,
        EXT_CAPTURE = 2'b10
    } ext_state_e;

endpackage : trouble_logger_pkg

/* File: bench/trouble_logger_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module trouble_logger_checker (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    // APB
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // Host handshake
    input wire logic log_clear_request_i,
    input wire logic detect_flag_reset_i,
    input wire logic exchange_start_request_i,
    input wire logic layout_reload_i,
    input wire logic trouble_detected_flag_o,
    input wire logic response_error_indicator_o,
    // Reports and station status
    input wire logic trouble_valid_i,
    input wire logic [15:0] trouble_cat_i,
    input wire logic [6:0] trouble_station_i,
    input wire logic station_fault_o,
    input wire logic [6:0] station_fault_id_o
);
    logic calm;
    assign calm = !exchange_start_request_i && !log_clear_request_i && !layout_reload_i;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);
    AST_ACCESS_WAIT: assert property ($rose(penable_i) && psel_i |=> pready_o)
        else $error("pready late");
    AST_READY_PULSE: assert property (pready_o |=> !pready_o) else $error("pready too long");
    AST_ERR_QUAL: assert property (pslverr_o |-> pready_o) else $error("error without ready");
    AST_RDATA_IDLE: assert property (!pready_o |-> prdata_o == 32'h0000_0000) else $error("read data idle");
    AST_FLAG_SET: assert property (trouble_valid_i && trouble_cat_i == 16'h0000 && calm |=> trouble_detected_flag_o)
        else $error("flag not set");
    AST_FLAG_DROP: assert property (detect_flag_reset_i && !trouble_valid_i |=> !trouble_detected_flag_o)
        else $error("flag not reset");
    AST_FLAG_HOLD: assert property (trouble_detected_flag_o && !detect_flag_reset_i |=> trouble_detected_flag_o)
        else $error("flag dropped");
    AST_IND_SET: assert property (trouble_valid_i && trouble_cat_i == 16'h0000 && calm |=> response_error_indicator_o)
        else $error("indicator not set");
    AST_FAULT_CAUSE: assert property (station_fault_o |-> $past(trouble_valid_i) && station_fault_id_o == $past(trouble_station_i))
        else $error("fault without report");
    AST_NO_FAULT: assert property (!trouble_valid_i |=> !station_fault_o)
        else $error("spurious fault");
    cover property (pslverr_o);
    cover property (station_fault_o);
    cover property (trouble_detected_flag_o ##1 !trouble_detected_flag_o);
endmodule : trouble_logger_checker
bind fieldbus_trouble_logger trouble_logger_checker chk_u (.ref_clk_i, .rst_b_i, .psel_i, .penable_i, .prdata_o,
    .pready_o, .pslverr_o, .log_clear_request_i, .detect_flag_reset_i, .exchange_start_request_i, .layout_reload_i,
    .trouble_detected_flag_o, .response_error_indicator_o, .trouble_valid_i, .trouble_cat_i, .trouble_station_i,
    .station_fault_o, .station_fault_id_o);
`default_nettype wire

/* File: bench/slave_station_model.sv */
`timescale 1ns/1ps
`default_nettype none
module slave_station_model (
    // Clock
    input wire logic ref_clk_i,
    // Trouble report
    output logic trouble_valid_o,
    output logic [15:0] trouble_code_o,
    output logic [15:0] trouble_cat_o,
    output logic [6:0] trouble_station_o,
    output logic [7:0] trouble_len_o,
    output logic [47:0] trouble_detail_o,
    // Extended byte stream
    output logic ext_valid_o,
    output logic [7:0] ext_byte_o,
    output logic ext_last_o
);
    initial {trouble_valid_o, trouble_code_o, trouble_cat_o, trouble_station_o} = '0;
    initial {trouble_len_o, trouble_detail_o, ext_valid_o, ext_byte_o, ext_last_o} = '0;
    // One report; code, category and detail scrambled once released, station and length kept
    task send(input logic [15:0] c, input logic [15:0] k);
        @(posedge ref_clk_i);
        trouble_valid_o <= 1'b1;
        trouble_code_o <= c;
        trouble_cat_o <= k;
        trouble_station_o <= c[6:0];
        trouble_len_o <= 8'h06;
        trouble_detail_o <= {3{c}};
        @(posedge ref_clk_i);
        trouble_valid_o <= 1'b0;
        trouble_code_o <= ~c;
        trouble_cat_o <= ~k;
        trouble_detail_o <= ~{3{c}};
    endtask : send
    // Extended diagnostic bytes 0,1,2...
    task stream(input int n);
        for (int i = 0; i < n; i++)
        begin
            @(posedge ref_clk_i);
            ext_valid_o <= 1'b1;
            ext_byte_o <= 8'(i);
            ext_last_o <= (i == n - 1);
        end
        @(posedge ref_clk_i);
        ext_valid_o <= 1'b0;
        ext_byte_o <= ~ext_byte_o;
        ext_last_o <= 1'b0;
    endtask : stream
endmodule : slave_station_model
`default_nettype wire

/* File: bench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import trouble_logger_pkg::*;
    logic ref_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic mode = 1'b0, clr = 1'b0, frst = 1'b0, xstart = 1'b0, reload = 1'b0;
    logic [13:0] paddr = 14'h0000;
    logic [31:0] pwdata = 32'h0000_0000, prdata;
    logic pready, pslverr, flag, ind, tv, ev, el, rerr;
    logic [15:0] tc, tk, rdat;
    logic [6:0] ts;
    logic [7:0] tl, eb;
    logic [47:0] td;
    logic sfault;
    logic [6:0] sid;
    localparam int CLR = 4, FRST = 2, RELOAD = 1;
    int n_mismatch = 0, tests_run = 0;
    logic [16:0] rows [6] = '{{16'h0001, 1'b0}, {16'h0080, 1'b0}, {16'h0201, 1'b0},
        {16'h0200, 1'b0}, {16'h0002, 1'b1}, {16'h8000, 1'b1}};
    always #10 ref_clk = ~ref_clk;
    fieldbus_trouble_logger #(.CYCLES_PER_SECOND(10)) dut_u (.ref_clk_i(ref_clk), .rst_b_i(rst_b),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .log_mode_select_i(mode),
        .log_clear_request_i(clr), .detect_flag_reset_i(frst), .exchange_start_request_i(xstart),
        .layout_reload_i(reload), .trouble_detected_flag_o(flag), .response_error_indicator_o(ind),
        .trouble_valid_i(tv), .trouble_code_i(tc), .trouble_cat_i(tk), .trouble_station_i(ts),
        .trouble_len_i(tl), .trouble_detail_i(td), .ext_valid_i(ev), .ext_byte_i(eb), .ext_last_i(el),
        .station_fault_o(sfault), .station_fault_id_o(sid));
    slave_station_model slv_u (.ref_clk_i(ref_clk), .trouble_valid_o(tv), .trouble_code_o(tc),
        .trouble_cat_o(tk), .trouble_station_o(ts), .trouble_len_o(tl), .trouble_detail_o(td),
        .ext_valid_o(ev), .ext_byte_o(eb), .ext_last_o(el));
    task chk(input logic [15:0] g, input logic [15:0] e);
        tests_run++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("BAD %0t word %h want %h", $time, g, e);
        end
    endtask : chk
    task chk1(input logic g, input logic e);
        tests_run++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("BAD %0t bit %b want %b", $time, g, e);
        end
    endtask : chk1
    task apb(input logic w, input logic [11:0] idx, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {16'h0000, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge ref_clk);
            n++;
        end
        if (n == 20)
        begin
            n_mismatch++;
            $display("BAD %0t no ready", $time);
        end
        rdat = prdata[15:0];
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task rchk(input logic [11:0] idx, input logic [15:0] e);
        apb(1'b0, idx, 16'h0000);
        chk(rdat, e);
    endtask : rchk
    // One-cycle host request: CLR, FRST or RELOAD
    task pulse(input int k);
        @(posedge ref_clk);
        {clr, frst, reload} <= 3'(k);
        @(posedge ref_clk);
        {clr, frst, reload} <= 3'h0;
        @(posedge ref_clk);
    endtask : pulse
    task tally_and_finish;
        $display("compares %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        #200000;
        n_mismatch++;
        tally_and_finish;
    end
    initial
    begin
        repeat (5) @(posedge ref_clk);
        rst_b <= 1'b1;
        // ****************************************
        // Category rows
        // ****************************************
        foreach (rows[i])
        begin
            pulse(FRST);
            slv_u.send(16'h0100 + 16'(i), rows[i][16:1]);
            @(posedge ref_clk);
            chk1(flag, rows[i][0]);
        end
        $display("end rows");
        // ****************************************
        // Ring, flag reset, clear
        // ****************************************
        pulse(CLR);
        for (int i = 1; i <= 9; i++)
            slv_u.send(16'(i), 16'h0000);
        rchk(12'h7F8, 16'h0009);
        rchk(12'h7FD, 16'h0008);
        rchk(12'h81B, 16'h0002);
        rchk(12'h7F9, 16'h0006);
        pulse(FRST);
        chk1(flag, 1'b0);
        rchk(12'h7F8, 16'h0009);
        pulse(CLR);
        rchk(12'h7F8, 16'h0000);
        rchk(12'h81B, 16'h0000);
        $display("end ring");
        // ****************************************
        // Fixed mode
        // ****************************************
        mode <= 1'b1;
        for (int i = 1; i <= 10; i++)
            slv_u.send(16'(i), 16'h0000);
        rchk(12'h7F8, 16'h000A);
        rchk(12'h7FD, 16'h0007);
        rchk(12'h81B, 16'h0001);
        pulse(CLR);
        rchk(12'h7F8, 16'h0000);
        $display("end fixed");
        // ****************************************
        // Extended area
        // ****************************************
        slv_u.send(16'h0200, 16'h0800);
        slv_u.stream(30);
        rchk(12'h830, 16'h001A);
        rchk(12'h831, 16'h0080);
        rchk(12'h832, 16'h0100);
        slv_u.send(16'h0200, 16'h0000);
        slv_u.stream(3);
        slv_u.stream(5);
        rchk(12'h830, 16'h0003);
        rchk(12'h831, 16'h0000);
        apb(1'b1, 12'h830, 16'h5555);
        rchk(12'h830, 16'h0003);
        $display("end extended");
        // ****************************************
        // Mask writes, unmapped, reload
        // ****************************************
        xstart <= 1'b1;
        apb(1'b1, 12'h820, 16'h0000);
        rchk(12'h820, 16'h02B9);
        xstart <= 1'b0;
        apb(1'b1, 12'h820, 16'h0000);
        rchk(12'h820, 16'h0000);
        pulse(FRST);
        slv_u.send(16'h0033, 16'h0001);
        @(posedge ref_clk);
        chk1(flag, 1'b1);
        chk1(ind, 1'b1);
        chk1(sfault, 1'b1);
        chk({9'h000, sid}, 16'h0033);
        apb(1'b0, 12'h900, 16'h0000);
        chk1(rerr, 1'b1);
        chk(rdat, 16'h0000);
        pulse(RELOAD);
        rchk(12'h7F8, 16'h0000);
        apb(1'b1, 12'h824, 16'h0001);
        rchk(12'h824, 16'h0001);
        pulse(FRST);
        xstart <= 1'b1;
        slv_u.send(16'h0044, 16'h0000);
        @(posedge ref_clk);
        chk1(flag, 1'b0);
        repeat (12) @(posedge ref_clk);
        slv_u.send(16'h0045, 16'h0000);
        @(posedge ref_clk);
        chk1(flag, 1'b1);
        xstart <= 1'b0;
        $display("end mask");
        // ****************************************
        // Reset
        // ****************************************
        @(posedge ref_clk);
        rst_b <= 1'b0;
        repeat (5) @(posedge ref_clk);
        rst_b <= 1'b1;
        chk1(flag, 1'b0);
        rchk(12'h820, 16'h02B9);
        $display("end reset");
        tally_and_finish;
    end
endmodule : testbench
`default_nettype wire
